// ### host_slave_port.sv
// Host slave port: pin-level register access, attention request, latch handshake.
// Assumes host pins are asynchronous to I_CLK; event inputs come from logic on I_CLK.
`timescale 1ns/1ps
`include "hsp_defines.svh"
module host_slave_port #(
  parameter int N_EVENTS  = `HSP_N_EVENTS,
  parameter int WR_CYCLES = `HSP_WR_CYCLES
) (
  input  wire logic        I_CLK,
  input  wire logic        I_NRST,
  input  wire logic        I_CS_N,
  input  wire logic        I_HOST_WRITE_STROBE_N,
  input  wire logic        I_HOST_READ_STROBE_N,
  input  wire logic        I_ADDRESS_LATCH_STROBE,
  input  wire logic [3:0]  I_REGISTER_SELECT,
  input  wire logic [15:0] I_MUXED_ADDR_DATA_BUS,
  output logic      [15:0] O_MUXED_ADDR_DATA_BUS,
  output logic      [15:0] O_MUXED_ADDR_DATA_BUS_OE_N,
  input  wire logic        I_DMA_ACTIVE,
  input  wire logic        I_REMOTE_WRITE_ACTIVE,
  input  wire logic        I_LATCH_WRITE_ACK_N,
  output logic             O_PORT_LATCH_READ_ENABLE_N,
  output logic             O_BUF_WRITE_N,
  input  wire logic [hsp_pkg::reg_byte_t'(0)+N_EVENTS-1:0] I_EVENT,
  output logic             O_ATTENTION
);
  import hsp_pkg::*;

  // Elaboration guards; flags read back as one byte and the cycle counter is four bits
  if (N_EVENTS < 1 || N_EVENTS > 8)
  begin : g_bad_events
    $error("N_EVENTS must be 1 to 8");
  end
  if (WR_CYCLES < 1 || WR_CYCLES > 15)
  begin : g_bad_cycles
    $error("WR_CYCLES must be 1 to 15");
  end

  // Reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Pin synchronisers; stage one feeds only stage two
  localparam int SW = 17;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_meta;
  logic [SW-1:0] pin_sync;
  logic          wr_s_d;
  logic          ack_s_d;
  assign pin_raw = {I_CS_N, I_HOST_WRITE_STROBE_N, I_HOST_READ_STROBE_N, I_ADDRESS_LATCH_STROBE,
                    I_LATCH_WRITE_ACK_N, I_REGISTER_SELECT, I_MUXED_ADDR_DATA_BUS[7:0]};
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= {1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 12'h000};
      pin_sync <= {1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 12'h000};
      wr_s_d   <= 1'b1;
      ack_s_d  <= 1'b1;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      wr_s_d   <= pin_sync[15];
      ack_s_d  <= pin_sync[12];
    end
  end

  logic       cs_s;
  logic       rd_s;
  logic       als_s;
  logic [3:0] ra_s;
  logic [7:0] d_s;
  logic       wr_rise;
  logic       ack_fall;
  assign cs_s     = pin_sync[16];
  assign rd_s     = pin_sync[14];
  assign als_s    = pin_sync[13];
  assign ra_s     = pin_sync[11:8];
  assign d_s      = pin_sync[7:0];
  assign wr_rise  = pin_sync[15] && !wr_s_d;
  assign ack_fall = !pin_sync[12] && ack_s_d;

  // Register select latch and register writes
  logic [3:0]  sel;
  logic [3:0]  next_sel;
  reg_byte_t   mask;
  reg_byte_t   next_mask;
  reg_byte_t   gen_regs [16];
  logic        slave;
  logic        wr_hit;
  logic [N_EVENTS-1:0] flags;
  logic [N_EVENTS-1:0] clr;
  assign slave  = !cs_s && !I_DMA_ACTIVE;
  assign wr_hit = slave && wr_rise;

  always_comb
  begin
    next_sel  = sel;
    next_mask = mask;
    if (slave && als_s)
      next_sel = ra_s;
    if (wr_hit && sel == `HSP_IDX_EVENT_MASK)
      next_mask = d_s;
  end

  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel  <= 4'h0;
      mask <= `HSP_RST_EVENT_MASK;
      for (int i = 0; i < 16; i++)
        gen_regs[i] <= `HSP_RST_GENERAL;
    end
    else
    begin
      sel  <= next_sel;
      mask <= next_mask;
      if (wr_hit)
        gen_regs[sel] <= d_s;
    end
  end

  // Event flags, cleared by writing ones to the flag register
  assign clr = (wr_hit && sel == `HSP_IDX_EVENT_FLAG) ? d_s[N_EVENTS-1:0] : '0;
  for (genvar g = 0; g < N_EVENTS; g++)
  begin : g_flag
    event_flag_bit u_flag (
      .i_clk   (I_CLK),
      .i_rst_n (rst_n),
      .i_set   (I_EVENT[g]),
      .i_clear (clr[g]),
      .o_flag  (flags[g])
    );
  end

  // Read data mux and bus drive
  reg_byte_t   rdata;
  logic [15:0] next_bus;
  logic [15:0] next_bus_oe_n;
  logic        next_attention;
  always_comb
  begin
    rdata = gen_regs[sel];
    if (sel == `HSP_IDX_EVENT_FLAG)
      rdata = reg_byte_t'(flags);
    else if (sel == `HSP_IDX_EVENT_MASK)
      rdata = mask;
    next_bus       = 16'h0000;
    next_bus_oe_n  = 16'hffff;
    if (slave && !rd_s)
    begin
      next_bus      = {8'h00, rdata};
      next_bus_oe_n = 16'hff00;
    end
    next_attention = |(flags & mask[N_EVENTS-1:0]);
  end

  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_MUXED_ADDR_DATA_BUS      <= 16'h0000;
      O_MUXED_ADDR_DATA_BUS_OE_N <= 16'hffff;
      O_ATTENTION                <= 1'b0;
    end
    else
    begin
      O_MUXED_ADDR_DATA_BUS      <= next_bus;
      O_MUXED_ADDR_DATA_BUS_OE_N <= next_bus_oe_n;
      O_ATTENTION                <= next_attention;
    end
  end

  // Remote write: latch read enable first, then buffer write with it still held.
  // Acknowledges arriving mid cycle are dropped; the system paces one per cycle.
  rw_state_e  st;
  rw_state_e  next_st;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic       next_prd_n;
  logic       next_bwr_n;
  always_comb
  begin
    next_st    = st;
    next_cnt   = cnt;
    next_prd_n = 1'b1;
    next_bwr_n = 1'b1;
    case (st)
      ST_IDLE:
        if (ack_fall && I_REMOTE_WRITE_ACTIVE)
        begin
          next_st    = ST_LATCH_RD;
          next_prd_n = 1'b0;
        end
      ST_LATCH_RD:
      begin
        next_st    = ST_MEM_WR;
        next_cnt   = 4'(WR_CYCLES - 1);
        next_prd_n = 1'b0;
        next_bwr_n = 1'b0;
      end
      ST_MEM_WR:
        if (cnt == 4'h0)
          next_st = ST_IDLE;
        else
        begin
          next_cnt   = cnt - 4'h1;
          next_prd_n = 1'b0;
          next_bwr_n = 1'b0;
        end
      default:
        next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st                         <= ST_IDLE;
      cnt                        <= 4'h0;
      O_PORT_LATCH_READ_ENABLE_N <= 1'b1;
      O_BUF_WRITE_N              <= 1'b1;
    end
    else
    begin
      st                         <= next_st;
      cnt                        <= next_cnt;
      O_PORT_LATCH_READ_ENABLE_N <= next_prd_n;
      O_BUF_WRITE_N              <= next_bwr_n;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!rst_n);

  a_attn_follows: assert property ((|(flags & mask[N_EVENTS-1:0])) |=> O_ATTENTION)
    else $error("attention missing for unmasked flag");
  a_attn_masked: assert property (!(|(flags & mask[N_EVENTS-1:0])) |=> !O_ATTENTION)
    else $error("attention raised without unmasked flag");
  a_event_attn: assert property ((I_EVENT[0] && mask[0]) |=> ##1 O_ATTENTION)
    else $error("event did not raise attention");
  a_clear_flag: assert property ((clr[0] && !I_EVENT[0]) |=> !flags[0])
    else $error("flag not cleared by write");
  a_ack_starts: assert property ((st == ST_IDLE && ack_fall && I_REMOTE_WRITE_ACTIVE)
                                 |=> !O_PORT_LATCH_READ_ENABLE_N ##1 !O_BUF_WRITE_N)
    else $error("acknowledge did not start write cycle");
  a_prd_covers: assert property (!O_BUF_WRITE_N |-> !O_PORT_LATCH_READ_ENABLE_N)
    else $error("buffer write without latch read enable");
  a_upper_float: assert property (O_MUXED_ADDR_DATA_BUS_OE_N[15:8] == 8'hff)
    else $error("upper bus byte driven");
  a_cs_ignore: assert property ((cs_s && $stable(cs_s)) |=> ($stable(sel) && O_MUXED_ADDR_DATA_BUS_OE_N == 16'hffff))
    else $error("selects used while deselected");
  a_sel_hold: assert property ((!als_s && !$past(als_s)) |-> $stable(sel))
    else $error("select changed while latched");
  a_read_drive: assert property ((slave && !rd_s) |=> O_MUXED_ADDR_DATA_BUS[7:0] == $past(rdata))
    else $error("wrong read data");

  c_attention: cover property ($rose(O_ATTENTION));
  c_remote_wr: cover property (st == ST_MEM_WR && cnt == 4'h0);
  c_reg_read: cover property (O_MUXED_ADDR_DATA_BUS_OE_N == 16'hff00);
  c_mask_write: cover property (wr_hit && sel == `HSP_IDX_EVENT_MASK);
endmodule : host_slave_port

// ### hsp_defines.svh
// Constants for the host slave port: register indices, reset values, timing.
// Assumes inclusion by bare name from the package and the port modules.
`ifndef HSP_DEFINES_SVH
`define HSP_DEFINES_SVH
`define HSP_IDX_EVENT_FLAG 4'h7
`define HSP_IDX_EVENT_MASK 4'hf
`define HSP_RST_EVENT_MASK 8'h00
`define HSP_RST_GENERAL    8'h00
`define HSP_N_EVENTS       3
`define HSP_EV_RX          0
`define HSP_EV_TX          1
`define HSP_EV_DMA         2
`define HSP_WR_CYCLES      2
`endif

// ### hsp_pkg.sv
// Types shared by the host slave port modules.
// Assumes nothing beyond the defines header.
`include "hsp_defines.svh"
package hsp_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_LATCH_RD, ST_MEM_WR} rw_state_e;
  typedef logic [7:0] reg_byte_t;
endpackage : hsp_pkg

// ### event_flag_bit.sv
// One sticky event flag with set-over-clear priority.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module event_flag_bit (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_set,
  input  wire logic i_clear,
  output logic      o_flag
);
  logic next_flag;

  // Set wins so an event in the clearing cycle is not lost
  always_comb
  begin
    next_flag = o_flag;
    if (i_clear)
      next_flag = 1'b0;
    if (i_set)
      next_flag = 1'b1;
  end

  // Flag storage
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_flag <= 1'b0;
    else
      o_flag <= next_flag;
  end

  a_set_wins: assert property (@(posedge i_clk) disable iff (!i_rst_n) i_set |=> o_flag)
    else $error("event flag lost its set");
endmodule : event_flag_bit

// ### latch_partner.sv
// Model of the system side of the remote write latch.
// Assumes i_go is a one-cycle pulse from the bench on the system clock.
`timescale 1ns/1ps
module latch_partner (
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [7:0] i_item,
  input  wire logic       i_prd_n,
  output logic            o_ack_n,
  output logic [7:0]      o_local_bus
);
  logic [7:0] latch = 8'h00;
  logic [2:0] cnt   = 3'h0;
  initial o_ack_n = 1'b1;
  // Item enters the latch two cycles before ack falls; ack then holds 4 cycles
  always @(posedge i_clk)
  begin
    if (i_go)
      latch <= i_item;
    cnt <= i_go ? 3'h5 : (cnt != 3'h0 ? cnt - 3'h1 : 3'h0);
    o_ack_n <= !(cnt != 3'h0 && cnt != 3'h5);
  end
  // Undriven latch shows inverted data so a stale sample cannot match
  assign o_local_bus = i_prd_n ? ~latch : latch;
endmodule : latch_partner

// ### test_host_slave_port.sv
// Self-checking bench for the host slave port with a latch model.
// Assumes design and partner files are compiled before this one.
`timescale 1ns/1ps
module test_host_slave_port;
  import hsp_pkg::*;
  logic        clk, nrst, cs_n, wr_n, rd_n, als, dma, rwa, go;
  logic        ack_n, prd_n, bwr_n, att;
  logic [3:0]  rs;
  logic [15:0] din, dout, oe_n;
  logic [2:0]  ev;
  logic [7:0]  item, lbus;
  int          n_errors, num_checks, cyc;

  host_slave_port #(.N_EVENTS(3), .WR_CYCLES(2)) DUT (
    .I_CLK(clk), .I_NRST(nrst), .I_CS_N(cs_n), .I_HOST_WRITE_STROBE_N(wr_n),
    .I_HOST_READ_STROBE_N(rd_n), .I_ADDRESS_LATCH_STROBE(als), .I_REGISTER_SELECT(rs),
    .I_MUXED_ADDR_DATA_BUS(din), .O_MUXED_ADDR_DATA_BUS(dout), .O_MUXED_ADDR_DATA_BUS_OE_N(oe_n),
    .I_DMA_ACTIVE(dma), .I_REMOTE_WRITE_ACTIVE(rwa), .I_LATCH_WRITE_ACK_N(ack_n),
    .O_PORT_LATCH_READ_ENABLE_N(prd_n), .O_BUF_WRITE_N(bwr_n), .I_EVENT(ev), .O_ATTENTION(att));
  latch_partner PARTNER (.i_clk(clk), .i_go(go), .i_item(item), .i_prd_n(prd_n),
    .o_ack_n(ack_n), .o_local_bus(lbus));

  // Clock at 20 MHz
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    if (got !== exp)
      n_errors++;
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // Host write; select moves to s2 after the address strobe has fallen
  task automatic hw(input logic c, input logic [3:0] s, input logic [3:0] s2, input logic [7:0] d);
    als = 1'b1;
    rs = s;
    cs_n = c;
    wr_n = 1'b0;
    din = {8'h00, d};
    step(1);
    als = 1'b0;
    step(3);
    rs = s2;
    wr_n = 1'b1;
    step(5);
    cs_n = 1'b1;
    step(1);
  endtask : hw

  // Host read; data only judged when the low byte should be driven
  task automatic hr(input logic c, input logic [3:0] s, input logic [15:0] eoe, input logic [7:0] d);
    als = 1'b1;
    rs = s;
    cs_n = c;
    rd_n = 1'b0;
    step(1);
    als = 1'b0;
    step(4);
    chk(oe_n, eoe);
    if (eoe == 16'hff00)
      chk(dout, {8'h00, d});
    rd_n = 1'b1;
    step(4);
    cs_n = 1'b1;
    step(1);
  endtask : hr

  task automatic t_regs;
    hw(1'b0, 4'h3, 4'h3, 8'ha5);
    hr(1'b0, 4'h3, 16'hff00, 8'ha5);
    hr(1'b0, 4'h4, 16'hff00, 8'h00);
    hw(1'b1, 4'h3, 4'h3, 8'h5a);
    hr(1'b1, 4'h3, 16'hffff, 8'h00);
    dma = 1'b1;
    hw(1'b0, 4'h3, 4'h3, 8'h11);
    dma = 1'b0;
    hr(1'b0, 4'h3, 16'hff00, 8'ha5);
    hw(1'b0, 4'h3, 4'h4, 8'h3c);
    hr(1'b0, 4'h3, 16'hff00, 8'h3c);
    hr(1'b0, 4'h4, 16'hff00, 8'h00);
  endtask : t_regs

  // Each source: masked event stays quiet, unmasking raises it, write-one clears
  task automatic t_events;
    for (int k = 0; k < 3; k++)
    begin
      ev = 3'(1 << k);
      step(1);
      ev = 3'h0;
      step(2);
      chk({15'h0, att}, 16'h0000);
      hw(1'b0, 4'hf, 4'hf, 8'(1 << k));
      chk({15'h0, att}, 16'h0001);
      hr(1'b0, 4'h7, 16'hff00, 8'(1 << k));
      hw(1'b0, 4'h7, 4'h7, 8'(1 << k));
      chk({15'h0, att}, 16'h0000);
      ev = 3'(1 << k);
      step(1);
      ev = 3'h0;
      chk({15'h0, att}, 16'h0000);
      step(1);
      chk({15'h0, att}, 16'h0001);
      hw(1'b0, 4'h7, 4'h7, 8'(1 << k));
      chk({15'h0, att}, 16'h0000);
      hw(1'b0, 4'hf, 4'hf, 8'h00);
    end
  endtask : t_events

  // Two latch transfers, then an ack with remote write inactive
  task automatic t_remote;
    int np, nb, w;
    rwa = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      item = 8'h96 + 8'(k);
      go = 1'b1;
      step(1);
      go = 1'b0;
      np = 0;
      nb = 0;
      for (w = 0; w < 20 && prd_n !== 1'b0; w++)
        step(1);
      while (prd_n === 1'b0 && np < 10)
      begin
        np++;
        if (bwr_n === 1'b0)
          nb++;
        chk({8'h00, lbus}, {8'h00, item});
        step(1);
      end
      chk(16'(np), 16'h0003);
      chk(16'(nb), 16'h0002);
      step(4);
    end
    rwa = 1'b0;
    go = 1'b1;
    step(1);
    go = 1'b0;
    repeat (12)
    begin
      chk({14'h0, prd_n, bwr_n}, 16'h0003);
      step(1);
    end
  endtask : t_remote

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial
  begin
    {nrst, cs_n, wr_n, rd_n, als, dma, rwa, go} = 8'h70;
    rs = 4'h0;
    din = 16'h0000;
    ev = 3'h0;
    item = 8'h00;
    n_errors = 0;
    num_checks = 0;
    cyc = 0;
    step(12);
    nrst = 1'b1;
    step(6);
    chk({oe_n[15:0]}, 16'hffff);
    chk({13'h0, att, prd_n, bwr_n}, 16'h0003);
    t_regs();
    t_events();
    t_remote();
    tally_and_finish();
  end
endmodule : test_host_slave_port
